// >>> logic/scp_csum.sv
// Running 16-bit word checksum over a byte stream
`timescale 1ns/1ps
`default_nettype none
module scp_csum
   import scp_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic        clr,
   input  wire logic        en,
   input  wire logic [7:0]  data,
   output logic      [31:0] sum
);

   logic [7:0]  hi_ff;
   logic        have_hi_ff;
   logic [31:0] sum_ff;

   // Pair bytes high first, then add the word
   always_ff @(posedge clk_sys) begin
      if (!resetn || clr) begin
         hi_ff      <= 8'h00;
         have_hi_ff <= 1'b0;
         sum_ff     <= 32'h0000_0000;
      end else if (en) begin
         if (!have_hi_ff) begin
            hi_ff      <= data;
            have_hi_ff <= 1'b1;
         end else begin
            sum_ff     <= sum_ff + {16'h0000, hi_ff, data};
            have_hi_ff <= 1'b0;
         end
      end
   end

   assign sum = sum_ff;

endmodule // scp_csum
`default_nettype wire

// >>> logic/scp_host.sv
// Management side control packet framer and response checker
`timescale 1ns/1ps
`default_nettype none
module scp_host
   import scp_pkg::*;
(
   input  wire logic         CLK_SYS,
   input  wire logic         RESETN,
   input  wire logic         TX_CSUM_GEN,
   input  wire logic         RX_CSUM_VERIFY,
   input  wire logic         TX_IN_VALID,
   input  wire logic [7:0]   TX_IN_DATA,
   input  wire logic         TX_IN_LAST,
   output logic              TX_IN_READY,
   output logic              TX_OUT_VALID,
   output logic      [7:0]   TX_OUT_DATA,
   output logic              TX_OUT_LAST,
   input  wire logic         TX_OUT_READY,
   input  wire logic         RX_IN_VALID,
   input  wire logic [7:0]   RX_IN_DATA,
   input  wire logic         RX_IN_LAST,
   output logic              RX_DONE,
   output logic              RX_GOOD,
   output logic              RX_CSUM_PRESENT,
   output logic              RX_CSUM_BAD,
   output logic              RX_SHORT,
   output logic              RX_IS_RESP,
   output logic      [7:0]   RX_PKT_TYPE,
   output logic      [11:0]  RX_PLEN,
   output logic      [15:0]  RX_RESP_CODE,
   output logic      [15:0]  RX_REASON_CODE,
   output scp_resp_class_type RX_RESP_CLASS,
   output logic              RX_REASON_VENDOR,
   output logic              RX_REASON_CMD_SPEC
);

   // ****************************************************************
   // Transmit path
   // ****************************************************************
   scp_tx_state_type tx_state_ff, nxt_tx_state;
   logic [11:0]      tx_cnt_ff;
   logic [1:0]       tx_cks_idx_ff;
   logic             tx_in_ready_ff, nxt_tx_in_ready;
   logic             tx_out_valid_ff;
   logic [7:0]       tx_out_data_ff, nxt_tx_data;
   logic             tx_out_last_ff, nxt_tx_last;
   logic             tx_take, tx_gen_load, tx_load, tx_end;
   logic [11:0]      tx_pay_ofs, tx_pay_next;
   logic [31:0]      tx_sum, tx_comp;
   logic [23:0]      tx_cmp_ff;

   // Load strobes: input byte taken, or block makes a byte itself
   assign tx_take     = tx_in_ready_ff && TX_IN_VALID;
   assign tx_gen_load = (tx_state_ff != TX_PASS) && (!tx_out_valid_ff || TX_OUT_READY);
   assign tx_load     = tx_take || tx_gen_load;
   assign tx_pay_ofs  = tx_cnt_ff - PAY_START;
   assign tx_pay_next = tx_pay_ofs + 12'h001;
   assign tx_end      = tx_load && nxt_tx_last;

   // Compensation word, zero when generation is off
   assign tx_comp = TX_CSUM_GEN ? (~tx_sum + 32'h0000_0001) : 32'h0000_0000;

   // Next byte and state
   always_comb begin
      nxt_tx_state = tx_state_ff;
      nxt_tx_data  = 8'h00;
      nxt_tx_last  = 1'b0;
      case (tx_state_ff)
         TX_PASS : begin
            nxt_tx_data = TX_IN_DATA;
            if (tx_take && TX_IN_LAST) begin
               nxt_tx_state = (tx_pay_next[1:0] != 2'b00) ? TX_WPAD : TX_CKS;
            end
         end
         TX_WPAD : begin
            nxt_tx_data = 8'h00;
            if (tx_pay_next[1:0] == 2'b00) begin
               nxt_tx_state = TX_CKS;
            end
         end
         TX_CKS : begin
            nxt_tx_data = scp_be_byte(tx_comp, tx_cks_idx_ff);
            if (tx_cks_idx_ff == 2'b11) begin
               nxt_tx_last  = (tx_cnt_ff >= MIN_LAST_IDX);
               nxt_tx_state = nxt_tx_last ? TX_PASS : TX_EPAD;
            end
         end
         TX_EPAD : begin
            nxt_tx_data = 8'h00;
            nxt_tx_last = (tx_cnt_ff >= MIN_LAST_IDX);
            if (nxt_tx_last) begin
               nxt_tx_state = TX_PASS;
            end
         end
         default : begin
            nxt_tx_state = TX_PASS;
         end
      endcase
      if (!tx_load) begin
         nxt_tx_state = tx_state_ff;
      end
   end

   // Input ready only when the output slot is empty next cycle
   assign nxt_tx_in_ready = (nxt_tx_state == TX_PASS) && !tx_load
                            && (!tx_out_valid_ff || TX_OUT_READY);

   // State, byte index and compensation byte index
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         tx_state_ff    <= TX_PASS;
         tx_cnt_ff      <= 12'h000;
         tx_cks_idx_ff  <= 2'b00;
         tx_in_ready_ff <= 1'b0;
      end else begin
         tx_state_ff    <= nxt_tx_state;
         tx_in_ready_ff <= nxt_tx_in_ready;
         if (tx_end) begin
            tx_cnt_ff <= 12'h000;
         end else if (tx_load && tx_cnt_ff != CNT_MAX) begin
            tx_cnt_ff <= tx_cnt_ff + 12'h001;
         end
         if (tx_load && tx_state_ff == TX_CKS) begin
            tx_cks_idx_ff <= tx_cks_idx_ff + 2'b01;
         end
      end
   end

   // Output register toward the MAC
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         tx_out_valid_ff <= 1'b0;
         tx_out_data_ff  <= 8'h00;
         tx_out_last_ff  <= 1'b0;
      end else if (tx_load) begin
         tx_out_valid_ff <= 1'b1;
         tx_out_data_ff  <= nxt_tx_data;
         tx_out_last_ff  <= nxt_tx_last;
      end else if (TX_OUT_READY) begin
         tx_out_valid_ff <= 1'b0;
      end
   end

   // Compensation bytes already sent, for checking only
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         tx_cmp_ff <= 24'h00_0000;
      end else if (tx_load && tx_state_ff == TX_CKS) begin
         tx_cmp_ff <= {tx_cmp_ff[15:0], nxt_tx_data};
      end
   end

   // Sum over control header, payload and payload pad
   scp_csum u_tx_csum (
      .clk_sys (CLK_SYS),
      .resetn  (RESETN),
      .clr     (tx_end),
      .en      (tx_load && (tx_state_ff == TX_PASS || tx_state_ff == TX_WPAD)
                && tx_cnt_ff >= ETH_HDR_LEN),
      .data    (nxt_tx_data),
      .sum     (tx_sum)
   );

   assign TX_IN_READY  = tx_in_ready_ff;
   assign TX_OUT_VALID = tx_out_valid_ff;
   assign TX_OUT_DATA  = tx_out_data_ff;
   assign TX_OUT_LAST  = tx_out_last_ff;

   // ****************************************************************
   // Receive path
   // ****************************************************************
   logic [11:0] rx_cnt_ff;
   logic [7:0]  rx_ptype_ff;
   logic [11:0] rx_plen_ff;
   logic [31:0] rx_comp_ff, rx_stat_ff, rx_sum, rx_total;
   logic [2:0]  rx_comp_n_ff;
   logic        rx_eval_ff;
   logic [12:0] rx_cend;
   logic        rx_in_sum, rx_in_comp;
   logic        rx_present, rx_bad, rx_short;
   scp_resp_class_type rx_class;
   logic        rx_rvend, rx_rcmd;

   // Checksum region ends after the padded payload
   assign rx_cend    = {1'b0, PAY_START} + scp_pad4(rx_plen_ff);
   assign rx_in_sum  = (rx_cnt_ff >= ETH_HDR_LEN) && ({1'b0, rx_cnt_ff} < rx_cend);
   assign rx_in_comp = !rx_in_sum && (rx_cnt_ff >= ETH_HDR_LEN)
                       && (rx_comp_n_ff < CSUM_BYTES);

   // Byte counter and field capture
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         rx_cnt_ff    <= 12'h000;
         rx_ptype_ff  <= 8'h00;
         rx_plen_ff   <= 12'h000;
         rx_comp_ff   <= 32'h0000_0000;
         rx_stat_ff   <= 32'h0000_0000;
         rx_comp_n_ff <= 3'h0;
         rx_eval_ff   <= 1'b0;
      end else begin
         rx_eval_ff <= RX_IN_VALID && RX_IN_LAST;
         if (rx_eval_ff) begin
            rx_comp_n_ff <= 3'h0;
         end
         if (RX_IN_VALID) begin
            if (RX_IN_LAST) begin
               rx_cnt_ff <= 12'h000;
            end else if (rx_cnt_ff != CNT_MAX) begin
               rx_cnt_ff <= rx_cnt_ff + 12'h001;
            end
            if (rx_cnt_ff == PTYPE_OFS) begin
               rx_ptype_ff <= RX_IN_DATA;
            end
            if (rx_cnt_ff == PLEN_HI_OFS) begin
               rx_plen_ff[11:8] <= RX_IN_DATA[3:0];
            end
            if (rx_cnt_ff == PLEN_LO_OFS) begin
               rx_plen_ff[7:0] <= RX_IN_DATA;
            end
            if (rx_cnt_ff >= PAY_START && rx_cnt_ff < PAY_START + 12'h004) begin
               rx_stat_ff <= {rx_stat_ff[23:0], RX_IN_DATA};
            end
            if (rx_in_comp) begin
               rx_comp_ff   <= {rx_comp_ff[23:0], RX_IN_DATA};
               rx_comp_n_ff <= rx_comp_n_ff + 3'h1;
            end
         end
      end
   end

   scp_csum u_rx_csum (
      .clk_sys (CLK_SYS),
      .resetn  (RESETN),
      .clr     (rx_eval_ff),
      .en      (RX_IN_VALID && rx_in_sum),
      .data    (RX_IN_DATA),
      .sum     (rx_sum)
   );

   scp_stat_dec u_stat_dec (
      .resp_code       (rx_stat_ff[31:16]),
      .reason_code     (rx_stat_ff[15:0]),
      .resp_class      (rx_class),
      .reason_vendor   (rx_rvend),
      .reason_cmd_spec (rx_rcmd)
   );

   // Verdict: zero field or verification off skips the check, else total must be zero
   assign rx_total   = rx_sum + rx_comp_ff;
   assign rx_present = (rx_comp_ff != 32'h0000_0000);
   assign rx_bad     = rx_present && RX_CSUM_VERIFY && (rx_total != 32'h0000_0000);
   assign rx_short   = (rx_comp_n_ff != CSUM_BYTES);

   // Result registers, updated once per frame
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         RX_DONE            <= 1'b0;
         RX_GOOD            <= 1'b0;
         RX_CSUM_PRESENT    <= 1'b0;
         RX_CSUM_BAD        <= 1'b0;
         RX_SHORT           <= 1'b0;
         RX_IS_RESP         <= 1'b0;
         RX_PKT_TYPE        <= 8'h00;
         RX_PLEN            <= 12'h000;
         RX_RESP_CODE       <= 16'h0000;
         RX_REASON_CODE     <= 16'h0000;
         RX_RESP_CLASS      <= RC_COMPLETED;
         RX_REASON_VENDOR   <= 1'b0;
         RX_REASON_CMD_SPEC <= 1'b0;
      end else begin
         RX_DONE <= rx_eval_ff;
         if (rx_eval_ff) begin
            RX_GOOD            <= !rx_short && !rx_bad;
            RX_CSUM_PRESENT    <= rx_present;
            RX_CSUM_BAD        <= rx_bad;
            RX_SHORT           <= rx_short;
            RX_IS_RESP         <= rx_ptype_ff[RESP_TYPE_BIT];
            RX_PKT_TYPE        <= rx_ptype_ff;
            RX_PLEN            <= rx_plen_ff;
            RX_RESP_CODE       <= rx_stat_ff[31:16];
            RX_REASON_CODE     <= rx_stat_ff[15:0];
            RX_RESP_CLASS      <= rx_class;
            RX_REASON_VENDOR   <= rx_rvend;
            RX_REASON_CMD_SPEC <= rx_rcmd;
         end
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);

   sequence s_pay_end;
      tx_take && TX_IN_LAST;
   endsequence

   sequence s_cks_first;
      tx_load && tx_state_ff == TX_CKS && tx_cks_idx_ff == 2'b00;
   endsequence

   a_pay_end_pad: assert property (
      s_pay_end |=> (tx_state_ff == (($past(tx_pay_next[1:0]) != 2'b00) ? TX_WPAD : TX_CKS)))
      else $error("payload end took the wrong pad path");

   a_wpad_zero: assert property (
      (tx_load && tx_state_ff == TX_WPAD) |=> (TX_OUT_DATA == 8'h00 && !TX_OUT_LAST))
      else $error("payload pad byte not zero");

   a_cks_aligned: assert property (
      s_cks_first |-> (tx_pay_ofs[1:0] == 2'b00))
      else $error("compensation field not word aligned");

   a_cks_off_zero: assert property (
      (tx_load && tx_state_ff == TX_CKS && !TX_CSUM_GEN) |=> (TX_OUT_DATA == 8'h00))
      else $error("compensation not zero with generation off");

   a_cks_sum_zero: assert property (
      (tx_load && tx_state_ff == TX_CKS && tx_cks_idx_ff == 2'b11 && TX_CSUM_GEN)
      |-> (({tx_cmp_ff, nxt_tx_data} + tx_sum) == 32'h0000_0000))
      else $error("compensation does not cancel the sum");

   a_min_frame: assert property (
      (tx_load && nxt_tx_last) |-> (tx_cnt_ff >= MIN_LAST_IDX && tx_state_ff != TX_PASS))
      else $error("frame shorter than minimum");

   a_epad_zero: assert property (
      (tx_load && tx_state_ff == TX_EPAD) |=> (TX_OUT_DATA == 8'h00))
      else $error("frame pad byte not zero");

   a_rx_zero_ok: assert property (
      (rx_eval_ff && !rx_short && !rx_present) |=> (RX_DONE && RX_GOOD && !RX_CSUM_BAD))
      else $error("zero compensation packet not accepted");

   a_rx_bad_drop: assert property (
      (rx_eval_ff && RX_CSUM_VERIFY && rx_present && rx_total != 32'h0000_0000)
      |=> (RX_DONE && !RX_GOOD))
      else $error("bad checksum packet accepted while verifying");

   a_rx_no_verify: assert property (
      (rx_eval_ff && !RX_CSUM_VERIFY && !rx_short) |=> RX_GOOD)
      else $error("packet rejected with verification off");

   a_rx_done_pulse: assert property (
      RX_DONE |=> !RX_DONE)
      else $error("done longer than one cycle");

endmodule // scp_host
`default_nettype wire

// >>> logic/scp_pkg.sv
// Constants, types and helpers for the control packet framer and checker
// Function
// - Payload fields travel in big-endian byte order
// - Multi-byte field puts most significant byte first
// - Zero-pad payload to 32-bit boundary
// - Compensation field holds two's complement checksum
// - Checksum is 32-bit sum of 16-bit words
// - Receiver adds compensation, intact when total zero
// - All-zero compensation means no checksum supplied
// - No checksum generated means zero compensation written
// - Receivers accept packets with zero compensation
// - Bad non-zero checksum may be silently dropped
// - Receiver may skip verifying non-zero checksums
// - Generation and verification are independent options
// - Pad frame to 64 bytes including FCS
// - Response code 2 bytes, upper range vendor
// - Codes: completed, failed, unavailable, unsupported
// - Reason upper byte command, low 0x80+ vendor
// - 16-byte control header precedes payload
// - Length field counts payload bytes only
package scp_pkg;

   // *****************************************************************
   // Frame layout, byte offsets from the first destination address byte
   // *****************************************************************
   localparam logic [11:0] ETH_HDR_LEN   = 12'h00e;
   localparam logic [11:0] CTL_HDR_LEN   = 12'h010;
   localparam logic [11:0] PAY_START     = ETH_HDR_LEN + CTL_HDR_LEN;
   localparam logic [11:0] PTYPE_OFS     = ETH_HDR_LEN + 12'h004;
   localparam logic [11:0] PLEN_HI_OFS   = ETH_HDR_LEN + 12'h006;
   localparam logic [11:0] PLEN_LO_OFS   = ETH_HDR_LEN + 12'h007;
   localparam logic [11:0] MIN_FRAME_LEN = 12'h040;
   localparam logic [11:0] FCS_LEN       = 12'h004;
   localparam logic [11:0] MIN_LAST_IDX  = MIN_FRAME_LEN - FCS_LEN - 12'h001;
   localparam logic [11:0] CNT_MAX       = 12'hfff;
   localparam logic [2:0]  CSUM_BYTES    = 3'h4;
   localparam int          RESP_TYPE_BIT = 7;

   // *****************************************************************
   // Status word codes
   // *****************************************************************
   localparam logic [15:0] RESP_COMPLETED  = 16'h0000;
   localparam logic [15:0] RESP_FAILED     = 16'h0001;
   localparam logic [15:0] RESP_UNAVAIL    = 16'h0002;
   localparam logic [15:0] RESP_UNSUPP     = 16'h0003;
   localparam logic [15:0] RESP_VENDOR_MIN = 16'h8000;
   localparam logic [7:0]  REASON_GENERIC  = 8'h00;
   localparam int          REASON_VEND_BIT = 7;

   // *****************************************************************
   // Types
   // *****************************************************************
   typedef enum logic [1:0] {
      TX_PASS = 2'b00,
      TX_WPAD = 2'b01,
      TX_CKS  = 2'b11,
      TX_EPAD = 2'b10
   } scp_tx_state_type;

   typedef enum logic [2:0] {
      RC_COMPLETED = 3'h0,
      RC_FAILED    = 3'h1,
      RC_UNAVAIL   = 3'h2,
      RC_UNSUPP    = 3'h3,
      RC_VENDOR    = 3'h4,
      RC_RESERVED  = 3'h5
   } scp_resp_class_type;

   // *****************************************************************
   // Helpers
   // *****************************************************************
   // Payload length rounded up to a whole word
   function automatic logic [12:0] scp_pad4(input logic [11:0] len);
      logic [12:0] t;
      t = {1'b0, len} + 13'h0003;
      return {t[12:2], 2'b00};
   endfunction

   // Byte of a word, index 0 is the most significant
   function automatic logic [7:0] scp_be_byte(input logic [31:0] w, input logic [1:0] idx);
      logic [4:0] sh;
      sh = {~idx, 3'b000};
      return 8'(w >> sh);
   endfunction

endpackage

// >>> logic/scp_stat_dec.sv
// Classifier for the response status word
`timescale 1ns/1ps
`default_nettype none
module scp_stat_dec
   import scp_pkg::*;
(
   input  wire logic [15:0]        resp_code,
   input  wire logic [15:0]        reason_code,
   output scp_resp_class_type      resp_class,
   output logic                    reason_vendor,
   output logic                    reason_cmd_spec
);

   // Standard codes by value, upper range vendor
   always_comb begin
      case (resp_code)
         RESP_COMPLETED : resp_class = RC_COMPLETED;
         RESP_FAILED    : resp_class = RC_FAILED;
         RESP_UNAVAIL   : resp_class = RC_UNAVAIL;
         RESP_UNSUPP    : resp_class = RC_UNSUPP;
         default        : resp_class = (resp_code >= RESP_VENDOR_MIN) ? RC_VENDOR
                                                                      : RC_RESERVED;
      endcase
   end

   // Reason upper byte names the command, low byte top half is vendor
   always_comb begin
      reason_cmd_spec = (reason_code[15:8] != REASON_GENERIC);
      reason_vendor   = reason_code[REASON_VEND_BIT];
   end

endmodule // scp_stat_dec
`default_nettype wire

// >>> testbench/scp_dev_model.sv
// Network controller model: stalling frame sink and response source
`timescale 1ns/1ps
`default_nettype none
module scp_dev_model
   import scp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_last,
   output logic            tx_ready,
   output logic            rx_valid,
   output logic      [7:0] rx_data,
   output logic            rx_last
);
   logic [7:0] cap[$];
   logic [7:0] fq[$];
   int         nfr = 0;
   int         last_idx = 0;

   // Word sum from byte a, queue holds whole words
   function automatic logic [31:0] csum(input logic [7:0] q[$], input int a);
      logic [31:0] s;
      s = 32'h0;
      for (int i = a; i < q.size(); i += 2)
         s += {q[i], q[i + 1]};
      return s;
   endfunction

   // Idle levels at start
   initial begin
      rx_valid = 1'b0;
      rx_last  = 1'b0;
      rx_data  = 8'h00;
   end

   // Random stalls of the frame sink
   always @(posedge clk)
      tx_ready <= ($urandom % 4) != 0;

   // Frame capture
   always @(posedge clk) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         cap.push_back(tx_data);
         if (tx_last === 1'b1) begin
            last_idx = cap.size() - 1;
            nfr++;
         end
      end
   end

   // Builds one response and streams it a byte per cycle
   task automatic respond(input logic [7:0] cmd, input logic [15:0] code,
                          input logic [15:0] rsn, input int n, input logic [1:0] mode);
      logic [31:0] c;
      int          p;
      fq = {};
      repeat (30) fq.push_back(8'h00);
      fq[18] = cmd | 8'h80;
      fq[21] = 8'(n);
      fq = {fq, code[15:8], code[7:0], rsn[15:8], rsn[7:0]};
      repeat (n - 4) fq.push_back(8'($urandom));
      while (fq.size() % 4 != 2) fq.push_back(8'h00);
      c = (mode == 2'd0) ? 32'h0 : -csum(fq, 14) ^ {31'h0, mode[1]};
      p = fq.size();
      fq = {fq, c[31:24], c[23:16], c[15:8], c[7:0]};
      while (fq.size() < 60) fq.push_back(8'($urandom));
      // Cut frame keeps only two compensation bytes
      if (mode == 2'd3)
         fq = fq[0:p + 1];
      foreach (fq[i]) begin
         rx_valid = 1'b1;
         rx_data  = fq[i];
         rx_last  = (i == fq.size() - 1);
         @(posedge clk) #1;
      end
      rx_valid = 1'b0;
      rx_last  = 1'b0;
      rx_data  = ~rx_data;
   endtask
endmodule // scp_dev_model
`default_nettype wire

// >>> testbench/testbench.sv
// Testbench for the control packet framer and response checker
`timescale 1ns/1ps
`default_nettype none
module testbench
   import scp_pkg::*;
;
   logic        CLK_SYS, RESETN, TX_CSUM_GEN, RX_CSUM_VERIFY, TX_IN_VALID, TX_IN_LAST;
   logic        TX_IN_READY, TX_OUT_VALID, TX_OUT_LAST, TX_OUT_READY, RX_IN_VALID, RX_IN_LAST;
   logic        RX_DONE, RX_GOOD, RX_CSUM_PRESENT, RX_CSUM_BAD, RX_SHORT, RX_IS_RESP;
   logic        RX_REASON_VENDOR, RX_REASON_CMD_SPEC;
   logic [7:0]  TX_IN_DATA, TX_OUT_DATA, RX_IN_DATA, RX_PKT_TYPE;
   logic [11:0] RX_PLEN;
   logic [15:0] RX_RESP_CODE, RX_REASON_CODE;
   scp_resp_class_type RX_RESP_CLASS;
   int          fails = 0;
   int          checks = 0;
   int          cyc = 0;
   int          tc[7] = '{0, 1, 2, 3, 5, 40, 30};
   logic [15:0] rc[6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h8000, 16'h7fff};

   // *****************************************************************
   // Design and far side
   // *****************************************************************
   scp_host DUT (.CLK_SYS, .RESETN, .TX_CSUM_GEN, .RX_CSUM_VERIFY, .TX_IN_VALID,
      .TX_IN_DATA, .TX_IN_LAST, .TX_IN_READY, .TX_OUT_VALID, .TX_OUT_DATA, .TX_OUT_LAST,
      .TX_OUT_READY, .RX_IN_VALID, .RX_IN_DATA, .RX_IN_LAST, .RX_DONE, .RX_GOOD,
      .RX_CSUM_PRESENT, .RX_CSUM_BAD, .RX_SHORT, .RX_IS_RESP, .RX_PKT_TYPE, .RX_PLEN,
      .RX_RESP_CODE, .RX_REASON_CODE, .RX_RESP_CLASS, .RX_REASON_VENDOR, .RX_REASON_CMD_SPEC);

   scp_dev_model dev (.clk(CLK_SYS), .tx_valid(TX_OUT_VALID), .tx_data(TX_OUT_DATA),
      .tx_last(TX_OUT_LAST), .tx_ready(TX_OUT_READY), .rx_valid(RX_IN_VALID),
      .rx_data(RX_IN_DATA), .rx_last(RX_IN_LAST));

   // Clock and hang guard
   initial begin
      CLK_SYS = 1'b0;
      forever #2.5 CLK_SYS = ~CLK_SYS;
   end
   always @(posedge CLK_SYS) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         results();
      end
   end

   // Compare and report
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s exp %h seen %h", nm, e, s);
      end
   endtask

   task automatic results();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Expected status class of a response code
   function automatic scp_resp_class_type cls(input logic [15:0] c);
      if (c >= 16'h8000)
         return RC_VENDOR;
      return (c > 16'h0003) ? RC_RESERVED : scp_resp_class_type'(c[2:0]);
   endfunction

   // One request frame through the handshake, output compared byte by byte
   task automatic tx_frame(input int n, input logic gen);
      logic [7:0]  q[$];
      logic [31:0] c;
      int          f0;
      f0 = dev.nfr;
      q = {};
      repeat (30 + n) q.push_back(8'($urandom));
      q[18] = q[18] & 8'h7f;
      q[20] = 8'h00;
      q[21] = 8'(n);
      TX_CSUM_GEN = gen;
      dev.cap = {};
      foreach (q[i]) begin
         TX_IN_VALID = 1'b1;
         TX_IN_DATA  = q[i];
         TX_IN_LAST  = (i == q.size() - 1);
         while (TX_IN_READY !== 1'b1) @(posedge CLK_SYS) #1;
         @(posedge CLK_SYS) #1;
      end
      TX_IN_VALID = 1'b0;
      TX_IN_LAST  = 1'b0;
      TX_IN_DATA  = ~TX_IN_DATA;
      while (q.size() % 4 != 2) q.push_back(8'h00);
      c = gen ? -dev.csum(q, 14) : 32'h0;
      q = {q, c[31:24], c[23:16], c[15:8], c[7:0]};
      while (q.size() < 60) q.push_back(8'h00);
      repeat (400) if (dev.nfr == f0) @(posedge CLK_SYS) #1;
      chk("tx frames", dev.nfr, f0 + 1);
      chk("tx last", dev.last_idx, q.size() - 1);
      foreach (q[i]) chk("tx byte", dev.cap[i], q[i]);
   endtask

   // One response from the far side, decoded status compared
   task automatic rx_frame(input logic [15:0] code, input logic [1:0] mode);
      logic [15:0] rsn;
      logic [31:0] s, c;
      int          n, p;
      logic        ver, bad, sh;
      rsn = 16'($urandom);
      n   = 4 + $urandom % 6;
      ver = 1'($urandom);
      sh  = (mode == 2'd3);
      RX_CSUM_VERIFY = ver;
      dev.respond(8'($urandom % 128), code, rsn, n, mode);
      chk("rx done early", RX_DONE, 1'b0);
      @(posedge CLK_SYS) #1;
      chk("rx done", RX_DONE, 1'b1);
      p = 30 + (n + 3) / 4 * 4;
      s = sh ? 32'h0 : dev.csum(dev.fq[0:p - 1], 14);
      c = sh ? 32'h0 : {dev.fq[p], dev.fq[p + 1], dev.fq[p + 2], dev.fq[p + 3]};
      bad = (c != 0) && ver && (s + c != 0);
      chk("rx short", RX_SHORT, sh);
      chk("rx good", RX_GOOD, !sh && !bad);
      if (!sh) begin
         chk("rx present", RX_CSUM_PRESENT, c != 0);
         chk("rx bad", RX_CSUM_BAD, bad);
         chk("rx type", RX_PKT_TYPE, dev.fq[18]);
         chk("rx is resp", RX_IS_RESP, 1'b1);
         chk("rx plen", RX_PLEN, n);
         chk("rx code", RX_RESP_CODE, code);
         chk("rx reason", RX_REASON_CODE, rsn);
         chk("rx class", RX_RESP_CLASS, cls(code));
         chk("rx vendor reason", RX_REASON_VENDOR, rsn[7]);
         chk("rx cmd reason", RX_REASON_CMD_SPEC, rsn[15:8] != 8'h00);
      end
      @(posedge CLK_SYS) #1;
      chk("rx done pulse", RX_DONE, 1'b0);
   endtask

   // Main sequence
   initial begin
      void'($urandom(77));
      {RESETN, TX_CSUM_GEN, RX_CSUM_VERIFY, TX_IN_VALID, TX_IN_LAST} = 5'h00;
      TX_IN_DATA = 8'h00;
      repeat (5) @(posedge CLK_SYS);
      #1;
      chk("reset out valid", TX_OUT_VALID, 1'b0);
      chk("reset done", RX_DONE, 1'b0);
      RESETN = 1'b1;
      for (int k = 0; k < 12; k++)
         tx_frame((k < 7) ? tc[k] : int'($urandom % 41), (k < 7) ? 1'(k % 2) : 1'($urandom));
      for (int k = 0; k < 18; k++)
         rx_frame((k < 6) ? rc[k] : 16'($urandom), (k < 6) ? 2'(k % 4) : 2'($urandom));
      results();
   end
endmodule // testbench
`default_nettype wire
